// file: logic/wdt_pkg.sv
/*
  package for the watchdog timer: register offsets, field layout, mode codes,
  reset values, timing constants and state encoding.
  assumes a 32-bit apb bus whose byte address is four times the register index.
*/
package wdt_pkg;

  // register indices and the byte addresses derived from them
  localparam logic [11:0] CTRL_INDEX = 12'h21f;
  localparam logic [11:0] STAT_INDEX = 12'h220;
  localparam logic [11:0] CTRL_ADDR  = 12'((32'(CTRL_INDEX)) * 4);
  localparam logic [11:0] STAT_ADDR  = 12'((32'(STAT_INDEX)) * 4);

  // watchdog_control field layout
  localparam int PRESCALE_LSB = 4;
  localparam int MODE_LSB     = 0;
  localparam int FIELD_W      = 4;

  // mode codes in the low field
  localparam logic [3:0] MODE_DISABLE = 4'h0;
  localparam logic [3:0] MODE_CLEAR   = 4'h5;
  localparam logic [3:0] MODE_ENABLE  = 4'hf;

  // status register field layout
  localparam int STAT_RUN_BIT    = 0;
  localparam int STAT_BITE_BIT   = 1;
  localparam int STAT_EXPIRE_BIT = 2;
  localparam int STAT_NBITE_LSB  = 8;
  localparam int STAT_COUNT_LSB  = 16;

  // values after reset
  localparam logic [3:0] PRESCALE_RESET = 4'h0;
  localparam logic       ENABLE_RESET   = 1'b1;

  // expiry limit in divided clock cycles
  localparam int TIMEOUT_TICKS = 65536;

  // width of the processor reset pulse
  localparam real BITE_TIME_NS   = 400.0;
  localparam real CLK_PERIOD_NS  = 40.0;
  localparam int  BITE_CYCLES    = (BITE_TIME_NS / CLK_PERIOD_NS < 1.0) ? 1 :
                                   int'($ceil(BITE_TIME_NS / CLK_PERIOD_NS));

  typedef enum logic [1:0] {
    WDT_OFF  = 2'b00,
    WDT_RUN  = 2'b01,
    WDT_BITE = 2'b10
  } wdt_state_t;

endpackage

// file: logic/wdt_tick_if.sv
/*
  carrier between the watchdog core and its pre-scaler.
  assumes both ends run on pclk and share presetn.
*/
`timescale 1ns/100ps
`default_nettype none

interface wdt_tick_if;
  logic [3:0] prescale;
  logic       restart;
  logic       tick;

  modport core (output prescale, output restart, input tick);
  modport div  (input prescale, input restart, output tick);
endinterface

`default_nettype wire

// file: logic/wdt_prescaler.sv
/*
  pre-scaler: one tick every (prescale + 1) base clock cycles.
  assumes the base clock is pclk and restart is a one-cycle pulse.
*/
`timescale 1ns/100ps
`default_nettype none

module wdt_prescaler (
  input  wire logic pclk,
  input  wire logic presetn,
  wdt_tick_if.div   tk
);

  logic [3:0] div_reg;
  logic [3:0] div_next;
  logic       tick_reg;
  logic       tick_next;

  // divide count, restarted by the core on any known mode write and on expiry
  always_comb begin
    div_next  = div_reg;
    tick_next = 1'b0;
    if (tk.restart) begin
      div_next = 4'h0;
    end else if (div_reg >= tk.prescale) begin
      div_next  = 4'h0;
      tick_next = 1'b1;
    end else begin
      div_next = div_reg + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg  <= 4'h0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tk.tick = tick_reg;

endmodule

`default_nettype wire

// file: logic/wdt_top.sv
/*
  watchdog timer with apb register access: divides the base clock by a
  programmable pre-scale and pulses a processor reset on expiry.
  assumes pclk is also the base clock and apb inputs are synchronous to it.
*/
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - tick rate is clock over prescale plus one
// - reset processor after 65536 uncleared ticks
// - expiry reset leaves control registers untouched
// - mode 0 disables, 5 clears, f enables
// - control register is write only
module wdt_top #(
  parameter int TIMEOUT = wdt_pkg::TIMEOUT_TICKS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             cpu_reset
);

  wdt_tick_if tk ();

  // prescale and enable state, plus counters
  logic [3:0]          prescale_reg;
  logic [3:0]          prescale_next;
  wdt_pkg::wdt_state_t state_reg;
  wdt_pkg::wdt_state_t state_next;
  logic [16:0]         count_reg;
  logic [16:0]         count_next;
  logic [7:0]          bite_cnt_reg;
  logic [7:0]          bite_cnt_next;
  logic [7:0]          nbite_reg;
  logic [7:0]          nbite_next;
  logic                expired_reg;
  logic                expired_next;
  logic                enable_reg;
  logic                enable_next;
  logic [31:0]         prdata_reg;
  logic [31:0]         prdata_next;
  logic                restart;

  // decoded bus strobes
  logic        setup;
  logic        access;
  logic        wr_ctrl;
  logic        wr_stat;
  logic [3:0]  mode_wr;
  logic        expire_now;
  logic        hold_off;

  localparam logic [16:0] LAST_COUNT = 17'(TIMEOUT - 1);
  localparam logic [7:0]  BITE_LAST  = 8'(wdt_pkg::BITE_CYCLES - 1);

  // address decode used by both read and write paths
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] base);
    addr_hit = (a == base);
  endfunction

  // true for the three documented mode codes
  function automatic logic mode_known(input logic [3:0] m);
    mode_known = (m == wdt_pkg::MODE_DISABLE) || (m == wdt_pkg::MODE_CLEAR) ||
                 (m == wdt_pkg::MODE_ENABLE);
  endfunction

  wdt_prescaler u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .tk      (tk)
  );

  // apb strobes; the low byte lane carries the control byte
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign wr_ctrl = access && pwrite && pstrb[0] && addr_hit(paddr, wdt_pkg::CTRL_ADDR);
  assign wr_stat = access && pwrite && pstrb[0] && addr_hit(paddr, wdt_pkg::STAT_ADDR);
  assign mode_wr = pwdata[wdt_pkg::MODE_LSB +: wdt_pkg::FIELD_W];

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access && !addr_hit(paddr, wdt_pkg::CTRL_ADDR) &&
                   !addr_hit(paddr, wdt_pkg::STAT_ADDR);

  // divider restarts on every known mode write and on expiry, so the first tick after a clear is a full period
  assign restart     = (wr_ctrl && mode_known(mode_wr)) || expire_now;
  assign tk.prescale = prescale_reg;
  assign tk.restart  = restart;

  // a clear or disable landing on the expiry tick wins, so no bite slips out
  assign hold_off   = wr_ctrl && ((mode_wr == wdt_pkg::MODE_CLEAR) ||
                                  (mode_wr == wdt_pkg::MODE_DISABLE));
  assign expire_now = (state_reg == wdt_pkg::WDT_RUN) && enable_reg && tk.tick &&
                      (count_reg >= LAST_COUNT) && !hold_off;

  // control register: prescale and mode actions
  always_comb begin
    prescale_next = prescale_reg;
    enable_next   = enable_reg;
    if (wr_ctrl) begin
      prescale_next = pwdata[wdt_pkg::PRESCALE_LSB +: wdt_pkg::FIELD_W];
      case (mode_wr)
        wdt_pkg::MODE_DISABLE: enable_next = 1'b0;
        wdt_pkg::MODE_ENABLE:  enable_next = 1'b1;
        default:               enable_next = enable_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_reg <= wdt_pkg::PRESCALE_RESET;
      enable_reg   <= wdt_pkg::ENABLE_RESET;
    end else begin
      // only presetn returns these to defaults, never the bite
      prescale_reg <= prescale_next;
      enable_reg   <= enable_next;
    end
  end

  // watchdog state machine and tick counter
  always_comb begin
    state_next    = state_reg;
    count_next    = count_reg;
    bite_cnt_next = bite_cnt_reg;
    case (state_reg)
      wdt_pkg::WDT_OFF: begin
        count_next = 17'h0;
        if (enable_reg) begin
          state_next = wdt_pkg::WDT_RUN;
        end
      end
      wdt_pkg::WDT_RUN: begin
        if (!enable_reg) begin
          state_next = wdt_pkg::WDT_OFF;
          count_next = 17'h0;
        end else if (wr_ctrl && (mode_wr == wdt_pkg::MODE_CLEAR)) begin
          count_next = 17'h0;
        end else if (expire_now) begin
          state_next    = wdt_pkg::WDT_BITE;
          count_next    = 17'h0;
          bite_cnt_next = 8'h0;
        end else if (tk.tick) begin
          count_next = count_reg + 17'h1;
        end
      end
      wdt_pkg::WDT_BITE: begin
        count_next = 17'h0;
        if (bite_cnt_reg >= BITE_LAST) begin
          state_next = enable_reg ? wdt_pkg::WDT_RUN : wdt_pkg::WDT_OFF;
        end else begin
          bite_cnt_next = bite_cnt_reg + 8'h1;
        end
      end
      default: begin
        state_next = wdt_pkg::WDT_OFF;
        count_next = 17'h0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= wdt_pkg::WDT_OFF;
      count_reg    <= 17'h0;
      bite_cnt_reg <= 8'h0;
    end else begin
      state_reg    <= state_next;
      count_reg    <= count_next;
      bite_cnt_reg <= bite_cnt_next;
    end
  end

  // sticky expiry flag and saturating expiry count
  always_comb begin
    expired_next = expired_reg;
    nbite_next   = nbite_reg;
    if (wr_stat && pwdata[wdt_pkg::STAT_EXPIRE_BIT]) begin
      expired_next = 1'b0;
    end
    if (expire_now) begin
      expired_next = 1'b1; // set wins over a clear in the same cycle
      if (nbite_reg != 8'hff) begin
        nbite_next = nbite_reg + 8'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expired_reg <= 1'b0;
      nbite_reg   <= 8'h0;
    end else begin
      expired_reg <= expired_next;
      nbite_reg   <= nbite_next;
    end
  end

  // read data captured in the setup cycle
  always_comb begin
    prdata_next = prdata_reg;
    if (setup) begin
      prdata_next = 32'h0; // control reads back zero
      if (!pwrite && addr_hit(paddr, wdt_pkg::STAT_ADDR)) begin
        prdata_next[wdt_pkg::STAT_RUN_BIT]    = (state_reg == wdt_pkg::WDT_RUN);
        prdata_next[wdt_pkg::STAT_BITE_BIT]   = (state_reg == wdt_pkg::WDT_BITE);
        prdata_next[wdt_pkg::STAT_EXPIRE_BIT] = expired_reg;
        prdata_next[wdt_pkg::STAT_NBITE_LSB +: 8]  = nbite_reg;
        prdata_next[wdt_pkg::STAT_COUNT_LSB +: 16] = count_reg[16:1];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

  // reset pulse to the processor core while biting
  assign cpu_reset = (state_reg == wdt_pkg::WDT_BITE);

endmodule

`default_nettype wire

// file: verif/wdt_asserts.sv
/*
  watchdog checker on the top ports.
  assumes every port is on pclk and presetn is async low.
*/
`timescale 1ns/100ps
`default_nettype none
module wdt_chk #(
  parameter int TIMEOUT = wdt_pkg::TIMEOUT_TICKS
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        cpu_reset
);
  // bus decode helpers
  wire acc = psel && penable;
  wire map = paddr == wdt_pkg::CTRL_ADDR || paddr == wdt_pkg::STAT_ADDR;
  wire cw  = acc && pwrite && pstrb[0] && paddr == wdt_pkg::CTRL_ADDR && !cpu_reset;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // pulse shape and quiet spans
  sequence s_bite;
    cpu_reset [*8] ##1 cpu_reset ##1 !cpu_reset;
  endsequence
  sequence s_calm;
    !cpu_reset [*8];
  endsequence
  // assertions
  a_bite_width: assert property ($rose(cpu_reset) |=> s_bite)
    else $error("bite pulse width wrong");
  a_clear_delays: assert property (cw && pwdata[3:0] == wdt_pkg::MODE_CLEAR |=> s_calm)
    else $error("bite too soon after clear");
  a_off_quiet: assert property (cw && pwdata[3:0] == wdt_pkg::MODE_DISABLE |=> s_calm ##1 s_calm)
    else $error("bite while disabled");
  a_enable_bites: assert property (cw && pwdata[7:0] == 8'h0f && TIMEOUT <= 24 |-> ##[1:40] cpu_reset)
    else $error("no bite after enable");
  a_ctrl_wo: assert property (acc && !pwrite && paddr == wdt_pkg::CTRL_ADDR |-> prdata == 32'h0)
    else $error("control read not zero");
  a_bad_addr: assert property (acc && !map |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_ok_addr: assert property (acc && map |-> !pslverr && pready)
    else $error("mapped access refused");
endmodule
bind wdt_top wdt_chk #(.TIMEOUT(TIMEOUT)) wdt_chk_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .cpu_reset(cpu_reset));
`default_nettype wire

// file: verif/tb_top.sv
/*
  watchdog bench: apb driver, read monitor, bite timing checks.
  assumes wdt_top with a short TIMEOUT and pclk as base clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int TO = 8;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        pready, pslverr, cpu_reset;
  logic [15:0] lf;
  logic [32:0] exq[$];
  int          err_count, cmp_count;
  wdt_top #(.TIMEOUT(TO)) wdt_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .cpu_reset(cpu_reset));
  // clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // random source
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic bad(input string s, input logic [32:0] e, input logic [32:0] g);
    err_count++;
    $display("ERROR %s exp %0h seen %0h", s, e, g);
  endtask
  task automatic summarize;
    $display("mismatches %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one apb transfer, then one idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // edges until the next bite, then wait it out
  task automatic gap(input int lo, input int hi);
    int n;
    n = 0;
    while (cpu_reset !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    cmp_count++;
    if (n < lo || n > hi) bad("bite gap", 33'(lo), 33'(n));
    while (cpu_reset === 1'b1) @(posedge pclk);
  endtask
  task automatic quiet(input int c);
    repeat (c) begin
      @(posedge pclk);
      cmp_count++;
      if (cpu_reset !== 1'b0) bad("cpu_reset", 33'h0, {32'h0, cpu_reset});
    end
  endtask
  // compare each read with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && exq.size() > 0) begin
      cmp_count++;
      if ({pslverr, prdata} !== exq[0]) bad("read", exq[0], {pslverr, prdata});
      void'(exq.pop_front());
    end
  end
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    lf = 16'h37b0;
    err_count = 0;
    cmp_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    gap(0, 14);
    for (int i = 0; i < 3; i++) begin
      lf = nx(lf);
      apb(1'b1, wdt_pkg::CTRL_ADDR, {lf[15:8], 16'h0, lf[3:0], wdt_pkg::MODE_CLEAR});
      gap(TO * (lf[3:0] + 1) - 2, TO * (lf[3:0] + 1) + 3);
    end
    apb(1'b1, wdt_pkg::CTRL_ADDR, 32'h35);
    gap(30, 35);
    gap(30, 39);
    $display("test prescale done");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, wdt_pkg::CTRL_ADDR, 32'h05);
      quiet(2);
    end
    gap(4, 11);
    $display("test clear done");
    apb(1'b1, wdt_pkg::CTRL_ADDR, 32'h00);
    quiet(60);
    // status after seven bites, then its sticky expiry bit cleared
    rd(wdt_pkg::STAT_ADDR, 33'h000000704);
    apb(1'b1, wdt_pkg::STAT_ADDR, 32'h4);
    rd(wdt_pkg::STAT_ADDR, 33'h000000700);
    for (int c = 1; c < 15; c++) begin
      if (c != 5) begin
        apb(1'b1, wdt_pkg::CTRL_ADDR, 32'(c));
        quiet(4);
      end
    end
    apb(1'b1, wdt_pkg::CTRL_ADDR, 32'h0f);
    gap(4, 11);
    pstrb <= 4'he;
    apb(1'b1, wdt_pkg::CTRL_ADDR, 32'h00);
    pstrb <= 4'hf;
    gap(0, 20);
    $display("test modes done");
    rd(wdt_pkg::CTRL_ADDR, 33'h0);
    rd(12'h004, 33'h100000000);
    repeat (2) @(posedge pclk);
    $display("test reads done");
    summarize();
  end
  // hang guard
  initial begin
    #400000;
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire
